// ===== test/fbd_link_master.sv
// link master model: takes four bytes per value, may stall
`timescale 1ns/1ps
module fbd_link_master (
  input  wire logic       core_clk,  // system clock
  input  wire logic       rst,       // async reset
  input  wire logic [7:0] byteData,  // byte from sender
  input  wire logic       byteValid, // byte offered
  input  wire logic       byteFirst, // byte one marker
  input  wire logic       slow,      // stall every other cycle
  output logic            byteReady, // byte taken
  output logic [31:0]     word,      // assembled value
  output logic [2:0]      count,     // bytes taken this word
  output logic            decValid,  // decoded value strobe
  output logic            decSign,   // decoded sign
  output logic [31:0]     decInt,    // integer part
  output logic [31:0]     decFrac    // fraction part, msb weighs one half
);
  logic        gotWord;
  int          unbiased;
  logic [63:0] fixedPt;
  // values of 2**32 and up or below 2**-32 fall off the ends of fixedPt
  always_comb begin
    unbiased = int'(word[30:23]) - 127;
    fixedPt  = {32'h1, word[22:0], 9'h0};
    if (unbiased >= 0) fixedPt = fixedPt << unbiased;
    else fixedPt = fixedPt >> (-unbiased);
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      byteReady <= 1'b0;
      count     <= 3'h0;
      word      <= 32'h0;
      gotWord   <= 1'b0;
      decValid  <= 1'b0;
      decSign   <= 1'b0;
      decInt    <= 32'h0;
      decFrac   <= 32'h0;
    end else begin
      byteReady <= slow ? ~byteReady : 1'b1;
      gotWord   <= byteValid && byteReady && !byteFirst && (count == 3'h3);
      decValid  <= gotWord;
      if (gotWord) begin
        decSign <= word[31];
        decInt  <= fixedPt[63:32];
        decFrac <= fixedPt[31:0];
      end
      if (byteValid && byteReady) begin
        word  <= {word[23:0], byteData};
        count <= byteFirst ? 3'h1 : count + 3'h1;
      end
    end
  end
endmodule

// ===== test/test_fbd_float_byte_sender.sv
// bench for the float byte sender
`timescale 1ns/1ps
module test_fbd_float_byte_sender;
  import fbd_pkg::*;
  logic          core_clk = 0, rst = 1, valValid = 0, slow = 0;
  fbd_value_type valIn = '0;
  logic          valReady, byteValid, byteReady, byteFirst, byteLast;
  logic [7:0]    byteData;
  logic [31:0]   word;
  logic [2:0]    count;
  logic          decValid, decSign;
  logic [31:0]   decInt, decFrac;
  int            errCount = 0, totalChecks = 0, cyc = 0;
  fbd_float_byte_sender u_dut (.core_clk(core_clk), .rst(rst), .valIn(valIn), .valValid(valValid),
    .valReady(valReady), .byteData(byteData), .byteValid(byteValid), .byteReady(byteReady),
    .byteFirst(byteFirst), .byteLast(byteLast));
  fbd_link_master u_far (.core_clk(core_clk), .rst(rst), .byteData(byteData), .byteValid(byteValid),
    .byteFirst(byteFirst), .slow(slow), .byteReady(byteReady), .word(word), .count(count),
    .decValid(decValid), .decSign(decSign), .decInt(decInt), .decFrac(decFrac));
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      errCount++;
      conclude();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task waitWord(input logic [31:0] exp, input logic [31:0] expInt, input logic [31:0] expFrac);
    bit seenHigh;
    seenHigh = 0;
    #1;
    if (byteValid && byteFirst) check(byteData, exp[31:24]);
    repeat (40) begin
      @(posedge core_clk);
      #1;
      if (byteValid && byteFirst) check(byteData, exp[31:24]);
      if (byteValid && byteLast) check(count, 3);
      if (byteValid) seenHigh = 1;
      else if (seenHigh) break;
    end
    check(word, exp);
    check(count, 4);
    @(posedge core_clk);
    #1;
    check(decValid, 1);
    check(decSign, exp[31]);
    check(decInt, expInt);
    check(decFrac, expFrac);
  endtask
  task send(input fbd_value_type v, input logic [31:0] exp, input logic [31:0] expInt, input logic [31:0] expFrac);
    @(posedge core_clk);
    valIn    <= v;
    valValid <= 1'b1;
    @(posedge core_clk);
    valValid <= 1'b0;
    waitWord(exp, expInt, expFrac);
  endtask
  // second value offered while busy must wait for the first to finish
  task busyRefuse;
    @(posedge core_clk);
    valIn    <= {1'b0, 8'h7E, 24'hC00000};
    valValid <= 1'b1;
    @(posedge core_clk);
    valIn <= {1'b1, 8'h81, 24'hC00000};
    waitWord(32'h3F400000, 32'h0, 32'hC0000000);
    @(posedge core_clk);
    valValid <= 1'b0;
    waitWord(32'hC0C00000, 32'h6, 32'h0);
  endtask
  task conclude;
    $display("errors %0d checks %0d", errCount, totalChecks);
    if (errCount == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    @(posedge core_clk);
    #1;
    check({valReady, byteValid}, 2'h2);
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    send({1'b0, 8'h7E, 24'hC00000}, 32'h3F400000, 32'h0, 32'hC0000000);
    send({1'b1, 8'h81, 24'hC00000}, 32'hC0C00000, 32'h6, 32'h0);
    send({1'b0, 8'h80, 24'hC00000}, 32'h40400000, 32'h3, 32'h0);
    send({1'b1, 8'h80, 24'h900000}, 32'hC0100000, 32'h2, 32'h40000000);
    send({1'b1, 8'h7D, 24'h800000}, 32'hBE800000, 32'h0, 32'h40000000);
    send({1'b0, 8'h7E, 24'h400000}, 32'h3F400000, 32'h0, 32'hC0000000);
    slow <= 1'b1;
    send({1'b0, 8'h85, 24'hBC5A69}, 32'h42BC5A69, 32'h5E, 32'h2D348000);
    busyRefuse();
    conclude();
  end
endmodule

// ===== verilog/fbd_byte_slicer.sv
// maps sign, biased power field and fraction onto the four link bytes
`timescale 1ns/1ps
`include "fbd_defines.svh"
module fbd_byte_slicer (
  input  fbd_pkg::fbd_value_type valIn,    // value with leading one in significand
  output fbd_pkg::fbd_bytes_type bytesOut  // index 0 is sent first
);
  import fbd_pkg::*;
  always_comb begin
    // leading one of the significand is never sent [RULE3]
    bytesOut[0] = {valIn.sign, valIn.biasedPowerField[`FBD_BPF_W-1:1]};                          // [RULE4]
    bytesOut[1] = {valIn.biasedPowerField[0], valIn.significand[`FBD_FRAC_MSB:`FBD_FRAC_B1LO]};  // [RULE5]
    bytesOut[2] = valIn.significand[`FBD_FRAC_B2HI:`FBD_FRAC_B2LO];                              // [RULE6]
    bytesOut[3] = valIn.significand[`FBD_FRAC_B3HI:0];                                           // [RULE6]
  end
endmodule

// ===== verilog/fbd_defines.svh
// constants for the float byte sender
`ifndef FBD_DEFINES_SVH
`define FBD_DEFINES_SVH
`define FBD_BYTE_W     8
`define FBD_BYTES      4
`define FBD_BPF_W      8
`define FBD_SIG_W      24
`define FBD_FRAC_MSB   22
`define FBD_FRAC_B1LO  16
`define FBD_FRAC_B2HI  15
`define FBD_FRAC_B2LO  8
`define FBD_FRAC_B3HI  7
`define FBD_IDX_W      2
`define FBD_IDX_FIRST  2'h0
`define FBD_IDX_SECOND 2'h1
`define FBD_IDX_THIRD  2'h2
`define FBD_IDX_LAST   2'h3
`define FBD_IDX_STEP   2'h1
`define FBD_BPF_HI     7
`define FBD_BPF_UPLO   1
`define FBD_BPF_LSB    0
`define FBD_FRAC_B3LO  0
`define FBD_SIGN_BIT   7
`define FBD_CNT_ZERO   3'h0
`define FBD_CNT_STEP   3'h1
`define FBD_CNT_LASTIN 3'h3
`define FBD_CNT_FULL   3'h4
`endif

// ===== verilog/fbd_float_byte_sender.sv
// sends one single-precision value as four bytes, most significant first
`timescale 1ns/1ps
`include "fbd_defines.svh"
// Behaviour
// [RULE1] every value leaves as exactly four bytes in single-precision binary layout
// [RULE2] receiver computes sign, power minus 127, times one plus fraction
// [RULE3] leading one of significand is dropped; receiver reinserts it
// [RULE4] first byte: sign in bit 7, power field bits 7..1 below
// [RULE5] second byte: power field bit 0 in bit 7, fraction 22..16 below
// [RULE6] third byte fraction 15..8, fourth byte fraction 7..0, msb high
// [RULE7] receiver shifts binary point by unbiased exponent, left if negative
// [RULE8] receiver weights integer bits by positive, fraction bits by negative powers
// [RULE9] receiver presents sign, integer, fraction with strobe a cycle after byte four
module fbd_float_byte_sender (
  input  wire logic                   core_clk,  // system clock
  input  wire logic                   rst,       // async reset, active high
  input  wire fbd_pkg::fbd_value_type valIn,     // value to send
  input  wire logic                   valValid,  // valIn offered
  output logic                        valReady,  // sender can take a value this cycle
  output logic [`FBD_BYTE_W-1:0]      byteData,  // byte on the link
  output logic                        byteValid, // byteData offered
  input  wire logic                   byteReady, // link takes byteData
  output logic                        byteFirst, // byteData is byte one
  output logic                        byteLast   // byteData is byte four
);
  import fbd_pkg::*;

  fbd_state_type state_reg;
  fbd_state_type state_next;
  fbd_bytes_type sliced;
  logic          take;
  logic          sent;

  fbd_byte_slicer slicer (
    .valIn    (valIn),
    .bytesOut (sliced)
  );

  // a new value is only taken when idle; this costs one bubble cycle between
  // words but keeps the byte order free of any overlap hazard
  assign valReady  = !state_reg.busy;
  assign take      = valValid && valReady;
  assign sent      = state_reg.busy && byteReady;
  assign byteValid = state_reg.busy;
  assign byteData  = state_reg.bytes[state_reg.idx];
  assign byteFirst = state_reg.busy && (state_reg.idx == `FBD_IDX_FIRST);
  assign byteLast  = state_reg.busy && (state_reg.idx == `FBD_IDX_LAST);

  always_comb begin
    state_next = state_reg;
    if (take) begin
      state_next.busy  = 1'b1;
      state_next.idx   = `FBD_IDX_FIRST;
      state_next.bytes = sliced;
      state_next.held  = valIn;
    end else if (sent) begin
      if (state_reg.idx == `FBD_IDX_LAST) begin // [RULE1]
        state_next.busy = 1'b0;
      end else begin
        state_next.idx = state_reg.idx + `FBD_IDX_STEP;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // helper: handshakes counted per word, read only by the checks below
  logic [`FBD_IDX_W:0] sentCount;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sentCount <= `FBD_CNT_ZERO;
    end else if (take) begin
      sentCount <= `FBD_CNT_ZERO;
    end else if (sent) begin
      sentCount <= sentCount + `FBD_CNT_STEP;
    end
  end

  // a word always closes after exactly four handshakes
  chk_four_bytes: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
    (sent && byteLast) |=> (sentCount == `FBD_CNT_FULL) && !byteValid)
    else $error("word did not end after four bytes");

  // first byte carries sign over the upper power field
  chk_first_byte: assert property (@(posedge core_clk) disable iff (rst) // [RULE4]
    take |=> byteFirst && byteData == {$past(valIn.sign), $past(valIn.biasedPowerField[`FBD_BPF_HI:`FBD_BPF_UPLO])})
    else $error("first byte does not hold sign and upper power field");

  // second byte: power field lsb over top fraction bits
  chk_second_byte: assert property (@(posedge core_clk) disable iff (rst) // [RULE5]
    (byteValid && state_reg.idx == `FBD_IDX_SECOND) |-> byteData == {state_reg.held.biasedPowerField[`FBD_BPF_LSB],
      state_reg.held.significand[`FBD_FRAC_MSB:`FBD_FRAC_B1LO]})
    else $error("second byte layout wrong");

  // third byte: middle fraction bits
  chk_third_byte: assert property (@(posedge core_clk) disable iff (rst) // [RULE6]
    (byteValid && state_reg.idx == `FBD_IDX_THIRD) |-> byteData == state_reg.held.significand[`FBD_FRAC_B2HI:`FBD_FRAC_B2LO])
    else $error("third byte layout wrong");

  // fourth byte: low fraction bits
  chk_fourth_byte: assert property (@(posedge core_clk) disable iff (rst) // [RULE6]
    byteLast |-> byteData == state_reg.held.significand[`FBD_FRAC_B3HI:`FBD_FRAC_B3LO])
    else $error("fourth byte layout wrong");

  // each accepted byte before the last is followed by the next index
  chk_byte_order: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
    (sent && !byteLast) |=> byteValid && (state_reg.idx == $past(state_reg.idx) + `FBD_IDX_STEP))
    else $error("bytes out of order");

  // the hidden one of the significand never reaches the byte buffer
  chk_hidden_dropped: assert property (@(posedge core_clk) disable iff (rst) // [RULE3]
    take |=> state_reg.bytes == {$past(valIn.significand[`FBD_FRAC_B3HI:`FBD_FRAC_B3LO]),
                                 $past(valIn.significand[`FBD_FRAC_B2HI:`FBD_FRAC_B2LO]),
                                 $past(valIn.biasedPowerField[`FBD_BPF_LSB]),
                                 $past(valIn.significand[`FBD_FRAC_MSB:`FBD_FRAC_B1LO]),
                                 $past(valIn.sign), $past(valIn.biasedPowerField[`FBD_BPF_HI:`FBD_BPF_UPLO])})
    else $error("leading significand bit leaked into bytes");

  // a stalled byte must not change under the receiver
  chk_hold_stall: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
    (byteValid && !byteReady) |=> byteValid && $stable(byteData))
    else $error("byte changed while stalled");

  // a value offered mid-word must not disturb the word in flight
  chk_refuse_busy: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
    (byteValid && !(sent && byteLast)) |=> $stable(state_reg.held))
    else $error("value taken while busy");

  // first and last markers never stand together
  chk_first_last: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
    byteFirst |-> !byteLast)
    else $error("first and last marker together");

  // markers stay low while nothing is offered
  chk_idle_quiet: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
    !byteValid |-> !byteFirst && !byteLast)
    else $error("marker high while idle");

  // no partial words: valid holds until the last byte is gone
  chk_no_early_end: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
    (byteValid && !byteLast) |=> byteValid)
    else $error("word ended before its last byte");

  // the sender is ready again right after a word
  chk_idle_bubble: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
    (sent && byteLast) |=> valReady)
    else $error("not ready after a finished word");

  // never more than four handshakes per word
  chk_count_bound: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
    sentCount <= `FBD_CNT_FULL)
    else $error("too many bytes in one word");

  // last byte is offered after three handshakes
  chk_last_count: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
    byteLast |-> sentCount == `FBD_CNT_LASTIN)
    else $error("last marker at wrong count");

  // a taken value starts a fresh word
  chk_take_start: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
    take |=> byteValid && (sentCount == `FBD_CNT_ZERO))
    else $error("word did not start after take");

  // byte one precedes byte two
  chk_second_next: assert property (@(posedge core_clk) disable iff (rst) // [RULE5]
    (sent && byteFirst) |=> state_reg.idx == `FBD_IDX_SECOND)
    else $error("second byte does not follow first");

  // byte two precedes byte three
  chk_third_next: assert property (@(posedge core_clk) disable iff (rst) // [RULE6]
    (sent && state_reg.idx == `FBD_IDX_SECOND) |=> state_reg.idx == `FBD_IDX_THIRD)
    else $error("third byte does not follow second");

  // byte three precedes byte four
  chk_fourth_next: assert property (@(posedge core_clk) disable iff (rst) // [RULE6]
    (sent && state_reg.idx == `FBD_IDX_THIRD) |=> byteLast)
    else $error("fourth byte does not follow third");

  // the held copy is the value that was offered
  chk_held_copy: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
    take |=> state_reg.held == $past(valIn))
    else $error("held value differs from offered value");

  // sign sits in the top bit of byte one
  chk_sign_top: assert property (@(posedge core_clk) disable iff (rst) // [RULE4]
    byteFirst |-> byteData[`FBD_SIGN_BIT] == state_reg.held.sign)
    else $error("sign not in top bit");

  // power field lsb sits in the top bit of byte two
  chk_power_low: assert property (@(posedge core_clk) disable iff (rst) // [RULE5]
    (byteValid && state_reg.idx == `FBD_IDX_SECOND) |-> byteData[`FBD_SIGN_BIT] == state_reg.held.biasedPowerField[`FBD_BPF_LSB])
    else $error("power field lsb misplaced");

  // a stall must not advance the byte index
  chk_stall_idx: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
    (byteValid && !byteReady) |=> $stable(state_reg.idx))
    else $error("index moved during stall");

  // byte one is offered before any handshake
  chk_first_count: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
    byteFirst |-> sentCount == `FBD_CNT_ZERO)
    else $error("first marker at wrong count");

  // first marker stands through a stall
  chk_stall_first: assert property (@(posedge core_clk) disable iff (rst) // [RULE4]
    (byteFirst && !byteReady) |=> byteFirst)
    else $error("first marker dropped during stall");

  // last marker stands through a stall
  chk_stall_last: assert property (@(posedge core_clk) disable iff (rst) // [RULE6]
    (byteLast && !byteReady) |=> byteLast)
    else $error("last marker dropped during stall");

  // middle bytes carry no marker
  chk_mid_flags: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
    (byteValid && (state_reg.idx == `FBD_IDX_SECOND || state_reg.idx == `FBD_IDX_THIRD)) |-> !byteFirst && !byteLast)
    else $error("marker on a middle byte");

  // each handshake inside a word counts once
  chk_count_step: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
    (sent && !byteLast) |=> sentCount == $past(sentCount) + `FBD_CNT_STEP)
    else $error("handshake count skipped");
endmodule

// ===== verilog/fbd_pkg.sv
// types for the float byte sender
`include "fbd_defines.svh"
package fbd_pkg;
  typedef struct packed {
    logic                      sign;
    logic [`FBD_BPF_W-1:0]     biasedPowerField;
    logic [`FBD_SIG_W-1:0]     significand;
  } fbd_value_type;

  typedef logic [`FBD_BYTES-1:0][`FBD_BYTE_W-1:0] fbd_bytes_type;

  typedef struct packed {
    logic                      busy;
    logic [`FBD_IDX_W-1:0]     idx;
    fbd_bytes_type             bytes;
    fbd_value_type             held;
  } fbd_state_type;
endpackage
